//--- pts_master_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "pts_defs.svh"

module pts_master_end (
   input wire logic MCLK_IN,
   input wire logic RESET_N_IN,
   input wire logic START_IN,
   input wire logic [31:0] START_ADDR_IN,
   input wire logic [63:0] WRITE_DATA_IN,
   input wire logic [7:0] BYTE_EN_N_IN,
   input wire logic WIDE_IN,
   input wire logic BACKEND_ACCEPT_IN,
   pts_link_if.master link,
   output logic MASTER_BUSY_OUT,
   output logic DONE_OUT,
   output logic [31:0] RX_ADDR_OUT,
   output logic [63:0] RX_DATA_OUT,
   output logic RX_VALID_OUT
);
   pts_pkg::pts_mst_state_t st_q;
   pts_pkg::pts_mst_state_t st_d;
   logic frame_n_q, frame_n_d, frame_oe_q, frame_oe_d;
   logic req64_n_q, req64_n_d, req64_oe_q, req64_oe_d;
   logic irdy_n_q, irdy_n_d, irdy_oe_q, irdy_oe_d;
   logic [63:0] ad_q;
   logic [63:0] ad_d;
   logic ad_oe_q, ad_oe_d;
   logic [7:0] cbe_q;
   logic [7:0] cbe_d;
   logic cbe_oe_q, cbe_oe_d;
   logic phase_q, phase_d, wide_q, wide_d, done_q, done_d;
   logic mbusy_q;
   logic mbusy_d;
   logic [31:0] addr_q;
   logic [31:0] addr_d;
   logic [63:0] wdata_q;
   logic [63:0] wdata_d;
   logic [7:0] wbe_q;
   logic [7:0] wbe_d;
   logic ready_n_q;
   logic hit_prev_q;
   logic [63:0] rx_q;
   logic [31:0] rx_addr_q;
   logic rx_valid_q;
   logic sel0;
   logic sel1;

   // Narrow transfers send the half named by the start address first.
   assign sel0 = addr_q[`PTS_QWORD_BIT];
   assign sel1 = !addr_q[`PTS_QWORD_BIT];

   always_comb begin
      st_d = st_q;
      frame_n_d = frame_n_q;
      frame_oe_d = frame_oe_q;
      req64_n_d = req64_n_q;
      req64_oe_d = req64_oe_q;
      irdy_n_d = irdy_n_q;
      irdy_oe_d = irdy_oe_q;
      ad_d = ad_q;
      ad_oe_d = ad_oe_q;
      cbe_d = cbe_q;
      cbe_oe_d = cbe_oe_q;
      phase_d = phase_q;
      wide_d = wide_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      wbe_d = wbe_q;
      done_d = 1'b0;
      unique case (st_q)
         pts_pkg::PTS_MST_IDLE: begin
            if (START_IN) begin
               addr_d = START_ADDR_IN;
               wdata_d = WRITE_DATA_IN;
               wbe_d = BYTE_EN_N_IN;
               wide_d = WIDE_IN;
               phase_d = 1'b0;
               frame_n_d = 1'b0; // R1
               frame_oe_d = 1'b1;
               req64_n_d = !WIDE_IN; // R1
               req64_oe_d = WIDE_IN;
               ad_d = {32'h0000_0000, START_ADDR_IN}; // R1
               ad_oe_d = 1'b1;
               cbe_d = {4'hF, `PTS_CMD_MEM_WRITE}; // R1
               cbe_oe_d = 1'b1;
               st_d = pts_pkg::PTS_MST_ADDR;
            end
         end
         pts_pkg::PTS_MST_ADDR: begin
            irdy_n_d = 1'b0; // R2
            irdy_oe_d = 1'b1;
            frame_n_d = !wide_q ? 1'b0 : 1'b1;
            if (wide_q) begin
               ad_d = wdata_q; // R2
               cbe_d = wbe_q; // R2
            end else begin
               ad_d = {32'h0000_0000, sel0 ? wdata_q[63:32] : wdata_q[31:0]};
               cbe_d = {4'hF, sel0 ? wbe_q[7:4] : wbe_q[3:0]};
            end
            st_d = pts_pkg::PTS_MST_DATA;
         end
         pts_pkg::PTS_MST_DATA: begin
            if (!link.trdy_n) begin
               if (!wide_q && !phase_q) begin
                  phase_d = 1'b1;
                  frame_n_d = 1'b1;
                  ad_d = {32'h0000_0000, sel1 ? wdata_q[63:32] : wdata_q[31:0]};
                  cbe_d = {4'hF, sel1 ? wbe_q[7:4] : wbe_q[3:0]};
               end else begin
                  frame_oe_d = 1'b0; // R8
                  req64_oe_d = 1'b0; // R8
                  ad_oe_d = 1'b0; // R8
                  cbe_oe_d = 1'b0; // R8
                  irdy_n_d = 1'b1; // R8
                  done_d = 1'b1;
                  st_d = pts_pkg::PTS_MST_TURN;
               end
            end
         end
         pts_pkg::PTS_MST_TURN: begin
            irdy_oe_d = 1'b0;
            st_d = pts_pkg::PTS_MST_IDLE;
         end
      endcase
      mbusy_d = frame_oe_d || irdy_oe_d;
   end

   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         st_q <= pts_pkg::PTS_MST_IDLE;
         frame_n_q <= 1'b1;
         frame_oe_q <= 1'b0;
         req64_n_q <= 1'b1;
         req64_oe_q <= 1'b0;
         irdy_n_q <= 1'b1;
         irdy_oe_q <= 1'b0;
         ad_q <= 64'h0000_0000_0000_0000;
         ad_oe_q <= 1'b0;
         cbe_q <= 8'hFF;
         cbe_oe_q <= 1'b0;
         phase_q <= 1'b0;
         wide_q <= 1'b0;
         addr_q <= 32'h0000_0000;
         wdata_q <= 64'h0000_0000_0000_0000;
         wbe_q <= 8'hFF;
         done_q <= 1'b0;
         mbusy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         frame_n_q <= frame_n_d;
         frame_oe_q <= frame_oe_d;
         req64_n_q <= req64_n_d;
         req64_oe_q <= req64_oe_d;
         irdy_n_q <= irdy_n_d;
         irdy_oe_q <= irdy_oe_d;
         ad_q <= ad_d;
         ad_oe_q <= ad_oe_d;
         cbe_q <= cbe_d;
         cbe_oe_q <= cbe_oe_d;
         phase_q <= phase_d;
         wide_q <= wide_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         wbe_q <= wbe_d;
         done_q <= done_d;
         mbusy_q <= mbusy_d;
      end
   end

   // Back-end: ready is raised while a window matches and BACKEND_ACCEPT_IN is high, one cycle ahead of data.
   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ready_n_q <= 1'b1;
         hit_prev_q <= 1'b0;
         rx_q <= 64'h0000_0000_0000_0000;
         rx_addr_q <= 32'h0000_0000;
         rx_valid_q <= 1'b0;
      end else begin
         ready_n_q <= !(|link.window_hit && BACKEND_ACCEPT_IN); // R6
         hit_prev_q <= |link.window_hit;
         rx_valid_q <= hit_prev_q && !(|link.window_hit);
         if (|link.window_hit && !hit_prev_q) begin
            rx_addr_q <= link.backend_addr;
         end
         if (!link.low_dword_strobe_n) begin
            rx_q[31:0] <= link.backend_data[31:0];
         end
         if (!link.high_dword_strobe_n) begin
            rx_q[63:32] <= link.backend_data[63:32];
         end
         if (!link.word_strobe_n) begin
            // For a QWORD-aligned start the DWORDs arrive low half first, so
            // shifting them in rebuilds the QWORD that was sent.
            rx_q <= {link.backend_data[31:0], rx_q[63:32]}; // R14
         end
      end
   end

   assign link.frame_n_o = frame_n_q;
   assign link.frame_oe = frame_oe_q;
   assign link.req64_n_o = req64_n_q;
   assign link.req64_oe = req64_oe_q;
   assign link.irdy_n_o = irdy_n_q;
   assign link.irdy_oe = irdy_oe_q;
   assign link.ad_o = ad_q;
   assign link.ad_oe = ad_oe_q;
   assign link.cbe_n_o = cbe_q;
   assign link.cbe_oe = cbe_oe_q;
   assign link.backend_ready_n = ready_n_q;
   assign MASTER_BUSY_OUT = mbusy_q;
   assign DONE_OUT = done_q;
   assign RX_ADDR_OUT = rx_addr_q;
   assign RX_DATA_OUT = rx_q;
   assign RX_VALID_OUT = rx_valid_q;
endmodule : pts_master_end

`default_nettype wire

//--- pts_defs.svh
`ifndef PTS_DEFS_SVH
`define PTS_DEFS_SVH

// Number of address windows that can claim a transaction.
`define PTS_NUM_WIN 6

// Window i covers PTS_WIN_BASE + i * PTS_WIN_SIZE under PTS_WIN_MASK.
`define PTS_WIN_BASE 32'h1000_0000
`define PTS_WIN_SIZE 32'h0010_0000
`define PTS_WIN_MASK 32'hFFF0_0000

// Bus command accepted by the target and issued by the master.
`define PTS_CMD_MEM_WRITE 4'h7

// Address bit that tells a QWORD-aligned start from a DWORD-aligned one.
`define PTS_QWORD_BIT 2

`endif

//--- pts_pkg.sv
package pts_pkg;

   typedef enum logic [2:0] {
      PTS_TGT_IDLE  = 3'h0,
      PTS_TGT_DEC   = 3'h1,
      PTS_TGT_MATCH = 3'h3,
      PTS_TGT_DATA  = 3'h2,
      PTS_TGT_DONE  = 3'h6
   } pts_tgt_state_t;

   typedef enum logic [1:0] {
      PTS_MST_IDLE = 2'h0,
      PTS_MST_ADDR = 2'h1,
      PTS_MST_DATA = 2'h3,
      PTS_MST_TURN = 2'h2
   } pts_mst_state_t;

endpackage : pts_pkg

//--- pts_link_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "pts_defs.svh"

interface pts_link_if;
   // Master side drives with enables; released control lines read as pulled up, released AD reads as zero.
   logic frame_n_o;
   logic frame_oe;
   logic req64_n_o;
   logic req64_oe;
   logic irdy_n_o;
   logic irdy_oe;
   logic [63:0] ad_o;
   logic ad_oe;
   logic [7:0] cbe_n_o;
   logic cbe_oe;
   logic frame_n;
   logic req64_n;
   logic irdy_n;
   logic [63:0] ad;
   logic [7:0] cbe_n;
   // Target answers on the bus.
   logic devsel_n;
   logic trdy_n;
   logic ack64_n;
   // Target to back-end.
   logic [31:0] backend_addr;
   logic wide_xfer_req_n;
   logic [`PTS_NUM_WIN-1:0] window_hit;
   logic [63:0] backend_data;
   logic [7:0] backend_be_n;
   logic low_dword_strobe_n;
   logic high_dword_strobe_n;
   logic word_strobe_n;
   // Back-end to target.
   logic backend_ready_n;

   assign frame_n = frame_oe ? frame_n_o : 1'b1;
   assign req64_n = req64_oe ? req64_n_o : 1'b1;
   assign irdy_n = irdy_oe ? irdy_n_o : 1'b1;
   assign ad = ad_oe ? ad_o : 64'h0000_0000_0000_0000;
   assign cbe_n = cbe_oe ? cbe_n_o : 8'hFF;

   modport target (
      input frame_n, req64_n, irdy_n, ad, cbe_n, backend_ready_n,
      output devsel_n, trdy_n, ack64_n, backend_addr, wide_xfer_req_n, window_hit,
      output backend_data, backend_be_n, low_dword_strobe_n, high_dword_strobe_n,
      output word_strobe_n
   );

   modport master (
      output frame_n_o, frame_oe, req64_n_o, req64_oe, irdy_n_o, irdy_oe,
      output ad_o, ad_oe, cbe_n_o, cbe_oe, backend_ready_n,
      input devsel_n, trdy_n, ack64_n, backend_addr, wide_xfer_req_n, window_hit,
      input backend_data, backend_be_n, low_dword_strobe_n, high_dword_strobe_n,
      input word_strobe_n
   );
endinterface : pts_link_if

`default_nettype wire

//--- pts_win_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "pts_defs.svh"

module pts_win_decode (
   input wire logic [31:0] addr_in,
   output logic [`PTS_NUM_WIN-1:0] hit_out
);
   genvar i;
   generate
      for (i = 0; i < `PTS_NUM_WIN; i = i + 1) begin : g_win
         assign hit_out[i] = ((addr_in & `PTS_WIN_MASK) ==
                              32'(`PTS_WIN_BASE + 32'(i) * `PTS_WIN_SIZE));
      end
   endgenerate
endmodule : pts_win_decode

`default_nettype wire

//--- pts_target_end.sv
// Operation
// R1 - Master starts with FRAME, REQ64, address, command.
// R2 - Master gives byte enables, IRDY, first data.
// R3 - Core forwards address, flags wide request low.
// R4 - Window match outputs appear in third clock.
// R5 - Slow select: DEVSEL and ACK64 after match.
// R6 - Back-end asserts ready one cycle ahead.
// R7 - TRDY follows the cycle of back-end ready.
// R8 - Master releases bus after IRDY and TRDY.
// R9 - Completion clears matches and both DWORD strobes.
// R10 - Narrow PCI uses two phases per QWORD.
// R11 - Latch QWORD, strobes tell which half moved.
// R12 - Aligned start means low half goes first.
// R13 - Narrow local mode pulses the word strobe.
// R14 - Back-end ignores upper half on narrow transfers; this back-end shifts both narrow words in, which rebuilds the QWORD for a QWORD-aligned start.
// R15 - Handshake outputs registered, inactive after reset.
`timescale 1ns/100ps
`default_nettype none
`include "pts_defs.svh"

module pts_target_end (
   input wire logic MCLK_IN,
   input wire logic RESET_N_IN,
   input wire logic PCI_WIDE_IN,
   input wire logic LOCAL_WIDE_IN,
   input wire logic SELECT_RESPONSE_SPEED_IN,
   pts_link_if.target link,
   output logic BUSY_OUT
);
   pts_pkg::pts_tgt_state_t st_q;
   pts_pkg::pts_tgt_state_t st_d;
   logic frame_prev_q;
   logic [31:0] addr_q;
   logic [31:0] addr_d;
   logic wide_q;
   logic wide_d;
   logic half_q;
   logic half_d;
   logic wide_req_n_q;
   logic wide_req_n_d;
   logic [`PTS_NUM_WIN-1:0] hit_q;
   logic [`PTS_NUM_WIN-1:0] hit_d;
   logic [`PTS_NUM_WIN-1:0] win_hit;
   logic devsel_n_q;
   logic devsel_n_d;
   logic ack64_n_q;
   logic ack64_n_d;
   logic trdy_n_q;
   logic trdy_n_d;
   logic [63:0] data_q;
   logic [63:0] data_d;
   logic [7:0] be_n_q;
   logic [7:0] be_n_d;
   logic lo_n_q;
   logic lo_n_d;
   logic hi_n_q;
   logic hi_n_d;
   logic word_n_q;
   logic word_n_d;
   logic busy_q;
   logic busy_d;
   logic start;
   logic xfer;
   logic last;

   // Window compare runs on the latched address so the match is a clean
   // registered output one clock after the address reaches the back-end.
   pts_win_decode u_dec (
      .addr_in (addr_q),
      .hit_out (win_hit)
   );

   assign start = frame_prev_q && !link.frame_n;
   assign xfer = !link.irdy_n && !trdy_n_q;
   assign last = link.frame_n;

   always_comb begin
      st_d = st_q;
      addr_d = addr_q;
      wide_d = wide_q;
      half_d = half_q;
      wide_req_n_d = wide_req_n_q;
      hit_d = hit_q;
      devsel_n_d = devsel_n_q;
      ack64_n_d = ack64_n_q;
      trdy_n_d = 1'b1;
      data_d = data_q;
      be_n_d = be_n_q;
      // Strobes are one-cycle marks of a finished data phase.
      lo_n_d = 1'b1;
      hi_n_d = 1'b1;
      word_n_d = 1'b1;
      busy_d = busy_q;
      unique case (st_q)
         pts_pkg::PTS_TGT_IDLE: begin
            if (start && link.cbe_n[3:0] == `PTS_CMD_MEM_WRITE) begin
               addr_d = link.ad[31:0]; // R3
               wide_d = PCI_WIDE_IN && !link.req64_n;
               wide_req_n_d = !(PCI_WIDE_IN && !link.req64_n); // R3
               half_d = link.ad[`PTS_QWORD_BIT]; // R12
               busy_d = 1'b1;
               st_d = pts_pkg::PTS_TGT_DEC;
            end
         end
         pts_pkg::PTS_TGT_DEC: begin
            if (|win_hit) begin
               hit_d = win_hit; // R4
               // Fast response claims the bus together with the match.
               devsel_n_d = SELECT_RESPONSE_SPEED_IN;
               ack64_n_d = SELECT_RESPONSE_SPEED_IN || !wide_q;
               st_d = pts_pkg::PTS_TGT_MATCH;
            end else begin
               wide_req_n_d = 1'b1;
               busy_d = 1'b0;
               st_d = pts_pkg::PTS_TGT_IDLE;
            end
         end
         pts_pkg::PTS_TGT_MATCH: begin
            devsel_n_d = 1'b0; // R5
            ack64_n_d = !wide_q; // R5
            trdy_n_d = link.backend_ready_n; // R7
            st_d = pts_pkg::PTS_TGT_DATA;
         end
         pts_pkg::PTS_TGT_DATA: begin
            trdy_n_d = link.backend_ready_n; // R7
            if (xfer) begin
               if (wide_q) begin
                  data_d = link.ad;
                  be_n_d = link.cbe_n;
                  lo_n_d = 1'b0;
                  hi_n_d = 1'b0;
               end else if (LOCAL_WIDE_IN) begin
                  // Each narrow phase fills one half of the held QWORD.
                  if (half_q) begin
                     data_d[63:32] = link.ad[31:0]; // R11
                     be_n_d[7:4] = link.cbe_n[3:0];
                     hi_n_d = 1'b0; // R11
                  end else begin
                     data_d[31:0] = link.ad[31:0]; // R11
                     be_n_d[3:0] = link.cbe_n[3:0];
                     lo_n_d = 1'b0; // R11
                  end
                  half_d = !half_q; // R10
               end else begin
                  data_d[31:0] = link.ad[31:0];
                  be_n_d[3:0] = link.cbe_n[3:0];
                  word_n_d = 1'b0; // R13
               end
               if (last) begin
                  trdy_n_d = 1'b1;
                  st_d = pts_pkg::PTS_TGT_DONE;
               end
            end
         end
         pts_pkg::PTS_TGT_DONE: begin
            hit_d = '0; // R9
            devsel_n_d = 1'b1;
            ack64_n_d = 1'b1;
            wide_req_n_d = 1'b1;
            busy_d = 1'b0;
            st_d = pts_pkg::PTS_TGT_IDLE;
         end
         default: begin
            hit_d = '0;
            devsel_n_d = 1'b1;
            ack64_n_d = 1'b1;
            wide_req_n_d = 1'b1;
            busy_d = 1'b0;
            st_d = pts_pkg::PTS_TGT_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin // R15
         st_q <= pts_pkg::PTS_TGT_IDLE;
         frame_prev_q <= 1'b1;
         addr_q <= 32'h0000_0000;
         wide_q <= 1'b0;
         half_q <= 1'b0;
         wide_req_n_q <= 1'b1;
         hit_q <= '0;
         devsel_n_q <= 1'b1;
         ack64_n_q <= 1'b1;
         trdy_n_q <= 1'b1;
         data_q <= 64'h0000_0000_0000_0000;
         be_n_q <= 8'hFF;
         lo_n_q <= 1'b1;
         hi_n_q <= 1'b1;
         word_n_q <= 1'b1;
         busy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         frame_prev_q <= link.frame_n;
         addr_q <= addr_d;
         wide_q <= wide_d;
         half_q <= half_d;
         wide_req_n_q <= wide_req_n_d;
         hit_q <= hit_d;
         devsel_n_q <= devsel_n_d;
         ack64_n_q <= ack64_n_d;
         trdy_n_q <= trdy_n_d;
         data_q <= data_d;
         be_n_q <= be_n_d;
         lo_n_q <= lo_n_d; // R9
         hi_n_q <= hi_n_d; // R9
         word_n_q <= word_n_d;
         busy_q <= busy_d;
      end
   end

   assign link.backend_addr = addr_q;
   assign link.wide_xfer_req_n = wide_req_n_q;
   assign link.window_hit = hit_q;
   assign link.devsel_n = devsel_n_q;
   assign link.ack64_n = ack64_n_q;
   assign link.trdy_n = trdy_n_q;
   assign link.backend_data = data_q;
   assign link.backend_be_n = be_n_q;
   assign link.low_dword_strobe_n = lo_n_q;
   assign link.high_dword_strobe_n = hi_n_q;
   assign link.word_strobe_n = word_n_q;
   assign BUSY_OUT = busy_q;
endmodule : pts_target_end

`default_nettype wire

//--- pts_link_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "pts_defs.svh"

module pts_link_chk (
   input wire logic MCLK_IN,
   input wire logic RESET_N_IN,
   input wire logic frame_n,
   input wire logic req64_n,
   input wire logic irdy_n,
   input wire logic [63:0] ad,
   input wire logic [7:0] cbe_n,
   input wire logic devsel_n,
   input wire logic trdy_n,
   input wire logic ack64_n,
   input wire logic [31:0] backend_addr,
   input wire logic wide_xfer_req_n,
   input wire logic [`PTS_NUM_WIN-1:0] window_hit,
   input wire logic backend_ready_n,
   input wire logic low_dword_strobe_n,
   input wire logic high_dword_strobe_n,
   input wire logic word_strobe_n
);
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   logic any_hit;
   logic any_half;
   logic any_strobe;
   logic half_seen_q;
   logic half_seen_d;

   assign any_hit = |window_hit;
   assign any_half = !low_dword_strobe_n || !high_dword_strobe_n;
   assign any_strobe = any_half || !word_strobe_n;

   // Only the first half moved in a write is judged for order, later halves alternate.
   always_comb begin
      half_seen_d = half_seen_q;
      if (!any_hit) begin
         half_seen_d = 1'b0;
      end else if (any_half) begin
         half_seen_d = 1'b1;
      end
   end

   always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         half_seen_q <= 1'b0;
      end else begin
         half_seen_q <= half_seen_d;
      end
   end

   sequence s_write_start;
      $fell(frame_n) && cbe_n[3:0] == `PTS_CMD_MEM_WRITE;
   endsequence

   sequence s_phase_before;
      $past(irdy_n) == 1'b0 && $past(trdy_n) == 1'b0;
   endsequence

   a_addr_handoff: assert property (s_write_start |-> ##1 backend_addr == $past(ad[31:0]))
      else $error("backend address differs from the address phase");
   a_wide_flag: assert property (s_write_start |-> ##1 wide_xfer_req_n == $past(req64_n))
      else $error("wide request flag does not follow the request");
   a_hit_two_after: assert property ($rose(any_hit) |-> $past(frame_n, 2) == 1'b0
      && $past(frame_n, 3) == 1'b1) else $error("window match not in the third clock");
   a_devsel_on_hit: assert property ($rose(any_hit) |-> ##[0:1] !devsel_n)
      else $error("select answer late after window match");
   a_ack_with_devsel: assert property ($fell(ack64_n) |-> $fell(devsel_n) && !wide_xfer_req_n)
      else $error("wide acknowledge apart from select");
   a_trdy_after_ready: assert property ($fell(trdy_n) |-> $past(backend_ready_n) == 1'b0)
      else $error("target ready without back-end ready before");
   a_trdy_in_claim: assert property (!trdy_n |-> any_hit && !devsel_n)
      else $error("target ready outside a claimed write");
   a_strobe_after_phase: assert property (any_strobe |-> s_phase_before)
      else $error("strobe without a completed data phase");
   a_wide_both_halves: assert property (any_half && !wide_xfer_req_n |->
      !low_dword_strobe_n && !high_dword_strobe_n) else $error("wide phase moved one half");
   a_first_half_order: assert property (any_half && wide_xfer_req_n && !half_seen_q |->
      low_dword_strobe_n == backend_addr[`PTS_QWORD_BIT]) else $error("wrong first half");
   a_clear_after_last: assert property ($fell(any_hit) |-> $past(any_strobe)
      && low_dword_strobe_n && high_dword_strobe_n) else $error("match cleared badly");
endmodule : pts_link_chk

`default_nettype wire

//--- pts_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "pts_defs.svh"

module tb;
   logic mclk, rst_n, pci_wide, local_wide, slow_sel, start, wide, accept;
   logic busy, mbusy, done, rx_valid, saw_ack, saw_wide, got;
   logic [31:0] start_addr, rx_addr, got_addr;
   logic [63:0] wr_data, rx_data, got_data;
   logic [`PTS_NUM_WIN-1:0] hit_seen;
   logic [1:0] first_strobe;
   int bad_count, n_checks, hit_at, sel_at, done_cnt;

   pts_link_if u_link();

   pts_target_end u_pts_target_end (.MCLK_IN(mclk), .RESET_N_IN(rst_n), .PCI_WIDE_IN(pci_wide),
      .LOCAL_WIDE_IN(local_wide), .SELECT_RESPONSE_SPEED_IN(slow_sel), .link(u_link.target),
      .BUSY_OUT(busy));
   pts_master_end u_pts_master_end (.MCLK_IN(mclk), .RESET_N_IN(rst_n), .START_IN(start),
      .START_ADDR_IN(start_addr), .WRITE_DATA_IN(wr_data), .BYTE_EN_N_IN(8'h00), .WIDE_IN(wide),
      .BACKEND_ACCEPT_IN(accept), .link(u_link.master), .MASTER_BUSY_OUT(mbusy),
      .DONE_OUT(done), .RX_ADDR_OUT(rx_addr), .RX_DATA_OUT(rx_data), .RX_VALID_OUT(rx_valid));
   pts_link_chk u_pts_link_chk (.MCLK_IN(mclk), .RESET_N_IN(rst_n), .frame_n(u_link.frame_n),
      .req64_n(u_link.req64_n), .irdy_n(u_link.irdy_n), .ad(u_link.ad), .cbe_n(u_link.cbe_n),
      .devsel_n(u_link.devsel_n), .trdy_n(u_link.trdy_n), .ack64_n(u_link.ack64_n),
      .backend_addr(u_link.backend_addr), .wide_xfer_req_n(u_link.wide_xfer_req_n),
      .window_hit(u_link.window_hit), .backend_ready_n(u_link.backend_ready_n),
      .low_dword_strobe_n(u_link.low_dword_strobe_n),
      .high_dword_strobe_n(u_link.high_dword_strobe_n), .word_strobe_n(u_link.word_strobe_n));

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [63:0] idle_levels();
      return 64'({busy, mbusy, u_link.window_hit, u_link.devsel_n, u_link.trdy_n, u_link.ack64_n,
         u_link.low_dword_strobe_n, u_link.high_dword_strobe_n, u_link.word_strobe_n});
   endfunction : idle_levels

   // Config pins are only changed under reset, since the target treats them as static.
   task automatic do_reset(input logic pw, input logic lw, input logic slow);
      @(posedge mclk);
      rst_n <= 1'b0;
      pci_wide <= pw;
      local_wide <= lw;
      slow_sel <= slow;
      repeat (4) @(posedge mclk);
      #1;
      check("reset_levels", 64'h0000_0000_0000_003F, idle_levels());
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
   endtask : do_reset

   task automatic launch(input logic [31:0] addr, input logic [63:0] data, input logic w);
      @(posedge mclk);
      start <= 1'b1;
      start_addr <= addr;
      wr_data <= data;
      wide <= w;
      @(posedge mclk);
      start <= 1'b0;
   endtask : launch

   task automatic do_write(input logic [31:0] addr, input logic [63:0] data, input logic w,
         input int hold, input int idx, input logic [63:0] mask, input logic [1:0] exp_first);
      @(posedge mclk);
      accept <= (hold == 0);
      launch(addr, data, w);
      got = 1'b0;
      hit_seen = '0;
      first_strobe = 2'b11;
      saw_ack = 1'b0;
      saw_wide = 1'b0;
      hit_at = -1;
      sel_at = -1;
      done_cnt = 0;
      for (int n = 0; n < 60 && !got; n++) begin
         @(posedge mclk);
         if (n == hold) accept <= 1'b1;
         #1;
         if (hit_at < 0 && |u_link.window_hit) begin
            hit_at = n;
            hit_seen = u_link.window_hit;
            check("busy_at_hit", 64'h0000_0000_0000_0003, 64'({busy, mbusy}));
         end
         if (sel_at < 0 && u_link.devsel_n === 1'b0) sel_at = n;
         if (u_link.ack64_n === 1'b0) saw_ack = 1'b1;
         if (u_link.wide_xfer_req_n === 1'b0) saw_wide = 1'b1;
         if (done === 1'b1) done_cnt++;
         if (first_strobe == 2'b11 && (u_link.low_dword_strobe_n === 1'b0
               || u_link.high_dword_strobe_n === 1'b0)) begin
            first_strobe = {u_link.high_dword_strobe_n, u_link.low_dword_strobe_n};
         end
         if (rx_valid === 1'b1) begin
            got = 1'b1;
            got_addr = rx_addr;
            got_data = rx_data;
         end
      end
      if (!got) begin
         bad_count++;
         $display("mismatch rx_valid expected 1 seen 0");
         test_done();
      end
      check("rx_addr", 64'(addr), 64'(got_addr));
      check("rx_data", data & mask, got_data & mask);
      check("window_hit", 64'(1) << idx, 64'(hit_seen));
      check("select_gap", 64'(slow_sel ? 1 : 0), 64'(sel_at - hit_at));
      check("ack64", 64'(w), 64'(saw_ack));
      check("wide_flag", 64'(w), 64'(saw_wide));
      check("first_half", 64'(exp_first), 64'(first_strobe));
      check("done_pulses", 64'h0000_0000_0000_0001, 64'(done_cnt));
      check("idle_levels", 64'h0000_0000_0000_003F, idle_levels());
   endtask : do_write

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      $display("mismatch run_length expected end seen limit");
      test_done();
   end

   initial begin
      logic [31:0] w1;
      bad_count = 0;
      n_checks = 0;
      rst_n = 1'b0;
      pci_wide = 1'b1;
      local_wide = 1'b1;
      slow_sel = 1'b1;
      start = 1'b0;
      wide = 1'b0;
      accept = 1'b1;
      start_addr = 32'h0000_0000;
      wr_data = 64'h0000_0000_0000_0000;
      w1 = `PTS_WIN_BASE + `PTS_WIN_SIZE;
      do_reset(1'b1, 1'b1, 1'b1);
      for (int i = 0; i < `PTS_NUM_WIN; i++) begin
         do_write(`PTS_WIN_BASE + 32'(i) * `PTS_WIN_SIZE, 64'h0123_4567_89AB_CDE0 + 64'(i),
            1'b1, (i == 5) ? 4 : 0, i, '1, 2'b00);
      end
      do_reset(1'b1, 1'b1, 1'b0);
      do_write(w1 + 32'h0000_0040, 64'hA5A5_5A5A_0F0F_F0F0, 1'b1, 2, 1, '1, 2'b00);
      do_write(w1 + 32'h0000_001C, 64'hC3C3_3C3C_9696_6969, 1'b0, 0, 1, '1, 2'b01);
      do_reset(1'b0, 1'b1, 1'b1);
      do_write(w1 + 32'h0000_0010, 64'h1111_2222_3333_4444, 1'b0, 0, 1, '1, 2'b10);
      do_write(w1 + 32'h0000_0014, 64'h5555_6666_7777_8888, 1'b0, 3, 1, '1, 2'b01);
      do_reset(1'b0, 1'b0, 1'b1);
      do_write(w1, 64'h9999_AAAA_BBBB_CCCC, 1'b0, 0, 1, '1, 2'b11);
      launch(32'h2000_0000, 64'h0000_0000_0000_0001, 1'b0);
      hit_seen = '0;
      sel_at = -1;
      repeat (20) begin
         @(posedge mclk);
         #1;
         hit_seen = hit_seen | u_link.window_hit;
         if (u_link.devsel_n !== 1'b1) sel_at = 0;
      end
      check("nohit_window", 64'h0000_0000_0000_0000, 64'(hit_seen));
      check("nohit_devsel", 64'hFFFF_FFFF_FFFF_FFFF, 64'(sel_at));
      do_reset(1'b1, 1'b1, 1'b1);
      do_write(`PTS_WIN_BASE, 64'hFEDC_BA98_7654_3210, 1'b1, 0, 0, '1, 2'b00);
      test_done();
   end
endmodule : tb

`default_nettype wire
